// ### rtl/reset_ctrl_defines.svh
`ifndef RESET_CTRL_DEFINES_SVH
`define RESET_CTRL_DEFINES_SVH

// Clock period of ref_clk
`define CLK_PERIOD_NS      4

// Least low time on the reset pin before it counts as a request
`define FILTER_TIME_NS     2000
`define FILTER_CYC         ((`FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Delay from power-on detection to the configuration read
`define CFG_DELAY_NS       10000000
`define CFG_DELAY_CYC      ((`CFG_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Stabilisation interval before the internal reset is released
`define RELEASE_NS         16000000
`define RELEASE_CYC        ((`RELEASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Clocks spent in the reset step before execution starts
`define STEP_CYC           5

// Program start vector
`define RESET_VECTOR       16'h0000

// Register offsets
`define OFS_LVI_CTRL       8'h86
`define OFS_BOR_CTRL       8'hd8
`define OFS_CAUSE_FLAGS    8'he8

// Register reset values
`define RST_LVI_CTRL       8'h00
`define RST_BOR_CTRL       8'h00
`define RST_CAUSE_FLAGS    8'h80

// Highest legal level codes
`define BOR_LEVEL_MAX      4'hd
`define LVI_LEVEL_MAX      4'hc

// Widths of the interval timer and the noise filter counter
`define TIMER_W            22
`define FILTER_W           9

`endif

// ### rtl/reset_ctrl_pkg.sv
package reset_ctrl_pkg;

	// Reset sequencer states
	typedef enum logic [2:0] {
		S_POR_DELAY,
		S_CFG_READ,
		S_STABILISE,
		S_STEP,
		S_RUN
	} seq_state_t;

	// Reset cause flag register layout
	typedef struct packed {
		logic       power_on_cause_flag;
		logic       ext_pin_cause_flag;
		logic       watchdog_cause_flag;
		logic       debug_cause_flag;
		logic       brownout_cause_flag;
		logic [2:0] rsvd;
	} reset_cause_flags_t;

	// Brown-out reset control register layout
	typedef struct packed {
		logic       stop_release_reenable;
		logic [1:0] rsvd;
		logic [3:0] brownout_level_sel;
		logic       brownout_disable_n;
	} brownout_reset_control_t;

	// Low-voltage indicator control register layout
	typedef struct packed {
		logic [1:0] rsvd;
		logic       undervoltage_warn_flag;
		logic       undervoltage_warn_enable;
		logic [3:0] undervoltage_warn_level;
	} low_voltage_indicator_control_t;

	// Qualified reset sources, same order as the cause flags
	typedef struct packed {
		logic ext_pin;
		logic watchdog;
		logic debug;
		logic brownout;
	} reset_src_t;

endpackage

// ### rtl/reset_noise_filter.sv
`timescale 1ns/1ns
`include "reset_ctrl_defines.svh"
module reset_noise_filter import reset_ctrl_pkg::*; (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic pin_n,
	output logic      low_q
);

	logic [`FILTER_W-1:0] cnt_q;
	logic [`FILTER_W-1:0] cnt_d;
	logic                 low_d;

	// Count consecutive low samples; a high sample restarts the count
	always_comb begin
		cnt_d = cnt_q;
		low_d = low_q;
		if (pin_n) begin
			cnt_d = '0;
			low_d = 1'b0;
		end else if (cnt_q == `FILTER_W'(`FILTER_CYC - 1)) begin
			low_d = 1'b1; // RULE1
		end else begin
			cnt_d = cnt_q + `FILTER_W'(1);
		end
	end

	// Filter state
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_q <= '0;
			low_q <= 1'b0;
		end else if (ce) begin
			cnt_q <= cnt_d;
			low_q <= low_d;
		end
	end

endmodule

// ### rtl/reset_interval_timer.sv
`timescale 1ns/1ns
`include "reset_ctrl_defines.svh"
module reset_interval_timer import reset_ctrl_pkg::*; (
	input  wire logic                ref_clk,
	input  wire logic                rst,
	input  wire logic                ce,
	input  wire logic                clr,
	output logic [`TIMER_W-1:0]      count_q
);

	logic [`TIMER_W-1:0] count_d;

	// Free count from zero, saturating so a long hold never wraps
	always_comb begin
		if (clr) begin
			count_d = '0;
		end else if (&count_q) begin
			count_d = count_q;
		end else begin
			count_d = count_q + `TIMER_W'(1);
		end
	end

	// Timer register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count_q <= '0;
		end else if (ce) begin
			count_q <= count_d;
		end
	end

endmodule

// ### rtl/reset_and_brownout_control.sv
// Function
// (RULE1) Ignore reset pin lows under about 2us
// (RULE2) Wait 10 ms after power-on before config read
// (RULE3) Latch option bytes before reset release
// (RULE4) Power-on release at 16 ms timer point
// (RULE5) Pin held low at least 10us
// (RULE6) Wait 16 ms after pin returns high
// (RULE7) Five-clock reset step, then vector 0000H
// (RULE8) Brown-out level 4-bit, codes 1110/1111 unavailable
// (RULE9) Brown-out enable bit is active low
// (RULE10) Stop release re-enables brown-out when selected
// (RULE11) Brown-out level/enable reset by power-on only
// (RULE12) Power-on flag set by power-on, cleared by 0
// (RULE13) Watchdog/debug flags cleared by 0 or power-on
// (RULE14) Pin/brown-out flags still set by own source
// (RULE15) Other resets set only their own flag
// (RULE16) Indicator enable, flag and 13-code level field
// (RULE17) Watchdog and brown-out gated by enable bits
// (RULE18) Any enabled source asserts internal reset
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`include "reset_ctrl_defines.svh"
module reset_and_brownout_control import reset_ctrl_pkg::*; #(
	parameter logic [`TIMER_W-1:0] CFG_DELAY_CYC = `TIMER_W'(`CFG_DELAY_CYC),
	parameter logic [`TIMER_W-1:0] RELEASE_CYC   = `TIMER_W'(`RELEASE_CYC)
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        ext_reset_n_pin,
	input  wire logic        watchdog_overflow,
	input  wire logic        watchdog_enable,
	input  wire logic        brownout_detect,
	input  wire logic        debug_reset_req,
	input  wire logic        lvi_detect,
	input  wire logic        stop_release,
	input  wire logic [7:0]  cfg_option_bytes,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_we,
	input  wire logic        reg_re,
	output logic      [7:0]  reg_rdata,
	output logic             sys_reset,
	output logic             cpu_start,
	output logic      [15:0] start_vector,
	output logic      [7:0]  config_options,
	output logic             brownout_disable_n,
	output logic      [3:0]  brownout_level_sel,
	output logic             undervoltage_warn_enable,
	output logic      [3:0]  undervoltage_warn_level
);

	// Level code is legal when not above the highest listed code
	function automatic logic level_ok(input logic [3:0] code, input logic [3:0] max);
		level_ok = (code <= max);
	endfunction

	// Strobe aimed at one register offset
	function automatic logic reg_hit(input logic strobe, input logic [7:0] addr,
		input logic [7:0] ofs);
		reg_hit = strobe && (addr == ofs);
	endfunction

	seq_state_t                     state_q;
	seq_state_t                     state_d;
	reset_cause_flags_t             cause_q;
	reset_cause_flags_t             cause_d;
	brownout_reset_control_t        bor_q;
	brownout_reset_control_t        bor_d;
	low_voltage_indicator_control_t lvi_q;
	low_voltage_indicator_control_t lvi_d;
	reset_src_t                     src;
	reset_src_t                     src_prev_q;
	reset_src_t                     evt;
	logic                           any_src;
	logic                           any_evt;
	logic                           ext_low;
	logic                           tmr_clr;
	logic [`TIMER_W-1:0]            tmr;
	logic [7:0]                     cfg_q;
	logic [7:0]                     cfg_d;
	logic                           sys_reset_q;
	logic                           sys_reset_d;
	logic                           cpu_start_q;
	logic                           cpu_start_d;
	logic [15:0]                    vector_q;
	logic [7:0]                     rdata_q;
	logic [7:0]                     rdata_d;
	logic                           wr_cause;
	logic                           wr_bor;
	logic                           wr_lvi;
	reset_cause_flags_t             cause_w;
	brownout_reset_control_t        bor_w;
	low_voltage_indicator_control_t lvi_w;

	// Glitch filter on the external reset pin
	reset_noise_filter u_filter (
		.ref_clk (ref_clk),
		.rst     (rst),
		.ce      (ce),
		.pin_n   (ext_reset_n_pin),
		.low_q   (ext_low)
	);

	// Interval timer used for every release delay
	reset_interval_timer u_timer (
		.ref_clk (ref_clk),
		.rst     (rst),
		.ce      (ce),
		.clr     (tmr_clr),
		.count_q (tmr)
	);

	// Qualified sources and their rising edges
	always_comb begin
		src.ext_pin  = ext_low;
		src.watchdog = watchdog_overflow & watchdog_enable;          // RULE17
		src.debug    = debug_reset_req;
		src.brownout = brownout_detect & ~bor_q.brownout_disable_n; // RULE9 RULE17
		evt          = src & ~src_prev_q;
		any_src      = |src;
		any_evt      = |evt;
	end

	// Reset sequencer next state
	always_comb begin
		state_d     = state_q;
		cfg_d       = cfg_q;
		cpu_start_d = 1'b0;
		unique case (state_q)
			S_POR_DELAY: begin
				if (tmr == CFG_DELAY_CYC - `TIMER_W'(1)) begin
					state_d = S_CFG_READ; // RULE2
				end
			end
			S_CFG_READ: begin
				cfg_d   = cfg_option_bytes; // RULE3
				state_d = S_STABILISE;
			end
			S_STABILISE: begin
				if (any_src) begin
					state_d = S_STABILISE; // RULE18
				end else if (tmr >= RELEASE_CYC - `TIMER_W'(1)) begin
					state_d = S_STEP; // RULE4 RULE6
				end
			end
			S_STEP: begin
				if (any_src) begin
					state_d = S_STABILISE; // RULE18
				end else if (tmr == `TIMER_W'(`STEP_CYC - 1)) begin
					state_d     = S_RUN; // RULE7
					cpu_start_d = 1'b1;
				end
			end
			S_RUN: begin
				if (any_src) begin
					state_d = S_STABILISE; // RULE18
				end
			end
		endcase
		// Timer restarts while a source holds after the option read, and on entry to the step
		tmr_clr = (any_src && (state_q == S_STABILISE || state_q == S_STEP
			|| state_q == S_RUN)) || (state_d == S_STEP && state_q != S_STEP);
		sys_reset_d = (state_d != S_RUN); // RULE18
	end

	// Sequencer registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q     <= S_POR_DELAY;
			cfg_q       <= 8'h00;
			sys_reset_q <= 1'b1;
			cpu_start_q <= 1'b0;
			vector_q    <= `RESET_VECTOR;
			src_prev_q  <= '0;
		end else if (ce) begin
			state_q     <= state_d;
			cfg_q       <= cfg_d;
			sys_reset_q <= sys_reset_d;
			cpu_start_q <= cpu_start_d;
			vector_q    <= `RESET_VECTOR; // RULE7
			src_prev_q  <= src;
		end
	end

	// Write data seen through each register's layout
	assign cause_w = reg_wdata;
	assign bor_w   = reg_wdata;
	assign lvi_w   = reg_wdata;

	// Cause flags next value; writing 0 clears, writing 1 keeps, a new reset wins
	always_comb begin
		wr_cause = reg_hit(reg_we, reg_addr, `OFS_CAUSE_FLAGS);
		cause_d  = cause_q;
		if (wr_cause) begin
			cause_d.power_on_cause_flag = cause_q.power_on_cause_flag
				& cause_w.power_on_cause_flag; // RULE12
			cause_d.ext_pin_cause_flag  = cause_q.ext_pin_cause_flag
				& cause_w.ext_pin_cause_flag;
			cause_d.watchdog_cause_flag = cause_q.watchdog_cause_flag
				& cause_w.watchdog_cause_flag; // RULE13
			cause_d.debug_cause_flag    = cause_q.debug_cause_flag
				& cause_w.debug_cause_flag; // RULE13
			cause_d.brownout_cause_flag = cause_q.brownout_cause_flag
				& cause_w.brownout_cause_flag;
		end
		// Each new reset sets its own flag only
		cause_d.ext_pin_cause_flag  = cause_d.ext_pin_cause_flag | evt.ext_pin;   // RULE14 RULE15
		cause_d.watchdog_cause_flag = cause_d.watchdog_cause_flag | evt.watchdog; // RULE13 RULE15
		cause_d.debug_cause_flag    = cause_d.debug_cause_flag | evt.debug;       // RULE13 RULE15
		cause_d.brownout_cause_flag = cause_d.brownout_cause_flag | evt.brownout; // RULE14 RULE15
		cause_d.rsvd                = 3'h0;
	end

	// Cause flag register; only power-on restores it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cause_q <= `RST_CAUSE_FLAGS; // RULE12 RULE13
		end else if (ce) begin
			cause_q <= cause_d;
		end
	end

	// Brown-out control next value; unavailable level codes are not taken
	always_comb begin
		wr_bor = reg_hit(reg_we, reg_addr, `OFS_BOR_CTRL);
		bor_d  = bor_q;
		if (wr_bor) begin
			bor_d.stop_release_reenable = bor_w.stop_release_reenable;
			bor_d.brownout_disable_n    = bor_w.brownout_disable_n; // RULE9
			if (level_ok(bor_w.brownout_level_sel, `BOR_LEVEL_MAX)) begin
				bor_d.brownout_level_sel = bor_w.brownout_level_sel; // RULE8
			end
		end
		// Stop release wins over a write in the same cycle
		if (stop_release && bor_q.stop_release_reenable) begin
			bor_d.brownout_disable_n = 1'b0; // RULE10
		end
		// Other resets drop the re-enable bit but keep level and enable
		if (any_evt) begin
			bor_d.stop_release_reenable = 1'b0; // RULE11
		end
		bor_d.rsvd = 2'h0;
	end

	// Brown-out control register; only power-on restores level and enable
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bor_q <= `RST_BOR_CTRL; // RULE11
		end else if (ce) begin
			bor_q <= bor_d;
		end
	end

	// Indicator control next value; flag is read/write and set by detection
	always_comb begin
		wr_lvi = reg_hit(reg_we, reg_addr, `OFS_LVI_CTRL);
		lvi_d  = lvi_q;
		if (wr_lvi) begin
			lvi_d.undervoltage_warn_flag   = lvi_w.undervoltage_warn_flag;
			lvi_d.undervoltage_warn_enable = lvi_w.undervoltage_warn_enable;
			if (level_ok(lvi_w.undervoltage_warn_level, `LVI_LEVEL_MAX)) begin
				lvi_d.undervoltage_warn_level = lvi_w.undervoltage_warn_level; // RULE16
			end
		end
		if (lvi_detect && lvi_q.undervoltage_warn_enable) begin
			lvi_d.undervoltage_warn_flag = 1'b1; // RULE16
		end
		lvi_d.rsvd = 2'h0;
		// Any reset other than power-on returns the indicator to its reset value
		if (any_evt) begin
			lvi_d = `RST_LVI_CTRL;
		end
	end

	// Indicator control register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lvi_q <= `RST_LVI_CTRL;
		end else if (ce) begin
			lvi_q <= lvi_d;
		end
	end

	// Read data for the cycle after the strobe only
	always_comb begin
		rdata_d = 8'h00;
		if (reg_re) begin
			unique case (reg_addr)
				`OFS_CAUSE_FLAGS: rdata_d = cause_q;
				`OFS_BOR_CTRL:    rdata_d = bor_q;
				`OFS_LVI_CTRL:    rdata_d = lvi_q;
				default:          rdata_d = 8'h00;
			endcase
		end
	end

	// Read data register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else if (ce) begin
			rdata_q <= rdata_d;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata                = rdata_q;
	assign sys_reset                = sys_reset_q;
	assign cpu_start                = cpu_start_q;
	assign start_vector             = vector_q;
	assign config_options           = cfg_q;
	assign brownout_disable_n       = bor_q.brownout_disable_n;
	assign brownout_level_sel       = bor_q.brownout_level_sel;
	assign undervoltage_warn_enable = lvi_q.undervoltage_warn_enable;
	assign undervoltage_warn_level  = lvi_q.undervoltage_warn_level;

endmodule

// ### tb/reset_far_side.sv
`timescale 1ns/1ns
module reset_far_side (
	input  wire logic ref_clk,
	output logic      pin_n,
	output logic      supply_low,
	output logic      warn_trip
);
	// Idle: pin at its pull-up level, supply healthy
	initial begin
		pin_n = 1'b1;
		supply_low = 1'b0;
		warn_trip = 1'b0;
	end
	// Hold the pin low for n clocks, then let the pull-up take it
	task automatic pull_low(input int n);
		@(posedge ref_clk) pin_n <= 1'b0;
		repeat (n) @(posedge ref_clk);
		pin_n <= 1'b1;
	endtask
	// Supply dip seen by the brown-out or the indicator comparator
	task automatic dip(input bit low_voltage_indicator, input int n);
		@(posedge ref_clk);
		warn_trip <= low_voltage_indicator;
		supply_low <= !low_voltage_indicator;
		repeat (n) @(posedge ref_clk);
		warn_trip <= 1'b0;
		supply_low <= 1'b0;
	endtask
endmodule

// ### tb/reset_and_brownout_control_sva.sv
`timescale 1ns/1ns
`include "reset_ctrl_defines.svh"
module reset_and_brownout_control_sva import reset_ctrl_pkg::*; #(
	parameter logic [`TIMER_W-1:0] CFG_DELAY_CYC = 20,
	parameter logic [`TIMER_W-1:0] RELEASE_CYC   = 40
) (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        ext_reset_n_pin,
	input wire logic        watchdog_overflow,
	input wire logic        watchdog_enable,
	input wire logic        brownout_detect,
	input wire logic        debug_reset_req,
	input wire logic        sys_reset,
	input wire logic        cpu_start,
	input wire logic [15:0] start_vector,
	input wire logic [7:0]  config_options,
	input wire logic        brownout_disable_n,
	input wire logic [3:0]  brownout_level_sel,
	input wire logic [3:0]  undervoltage_warn_level
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic        quiet;
	logic [23:0] calm_q;
	logic [23:0] since_q;
	// No enabled source asks for reset
	assign quiet = ext_reset_n_pin && !debug_reset_req && !(watchdog_overflow && watchdog_enable)
		&& !(brownout_detect && !brownout_disable_n);
	// Cycles of held reset with every source quiet
	always_ff @(posedge ref_clk) begin
		calm_q <= (rst || !sys_reset || !quiet) ? 24'h0 : calm_q + 24'h1;
	end
	// Cycles since the power-on reset was released, saturating
	always_ff @(posedge ref_clk) begin
		since_q <= rst ? 24'h0 : since_q + {23'h0, ~&since_q};
	end
	property p_vec; start_vector == 16'h0000; endproperty
	a_vec: assert property (p_vec) else $error("start vector not zero");
	property p_start; cpu_start |-> $fell(sys_reset); endproperty
	a_start: assert property (p_start) else $error("start pulse without release");
	property p_quiet; !sys_reset && quiet && $past(quiet) |=> !sys_reset; endproperty
	a_quiet: assert property (p_quiet) else $error("reset without source");
	property p_src; !sys_reset && !quiet && ext_reset_n_pin |=> sys_reset; endproperty
	a_src: assert property (p_src) else $error("source did not reset");
	property p_hold; $fell(sys_reset) |-> $past(calm_q) >= 24'(RELEASE_CYC); endproperty
	a_hold: assert property (p_hold) else $error("reset released early");
	property p_cfg; !sys_reset && !$past(sys_reset) |-> $stable(config_options); endproperty
	a_cfg: assert property (p_cfg) else $error("options moved while running");
	property p_cfg_time; $changed(config_options) |-> since_q == 24'(CFG_DELAY_CYC) + 24'h1; endproperty
	a_cfg_time: assert property (p_cfg_time) else $error("options read at wrong time");
	property p_lvl; brownout_level_sel <= 4'hd; endproperty
	a_lvl: assert property (p_lvl) else $error("brown-out level code illegal");
	property p_lvi; undervoltage_warn_level <= 4'hc; endproperty
	a_lvi: assert property (p_lvi) else $error("indicator level code illegal");
	c_start: cover property (cpu_start);
	c_rise: cover property ($rose(sys_reset));
	c_bo_off: cover property (brownout_detect && brownout_disable_n);
endmodule
bind reset_and_brownout_control reset_and_brownout_control_sva #(
	.CFG_DELAY_CYC(CFG_DELAY_CYC), .RELEASE_CYC(RELEASE_CYC)) u_sva (
	.ref_clk(ref_clk), .rst(rst), .ext_reset_n_pin(ext_reset_n_pin),
	.watchdog_overflow(watchdog_overflow), .watchdog_enable(watchdog_enable),
	.brownout_detect(brownout_detect), .debug_reset_req(debug_reset_req),
	.sys_reset(sys_reset), .cpu_start(cpu_start), .start_vector(start_vector),
	.config_options(config_options), .brownout_disable_n(brownout_disable_n),
	.brownout_level_sel(brownout_level_sel),
	.undervoltage_warn_level(undervoltage_warn_level));

// ### tb/reset_and_brownout_control_tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
	$display("[FAIL] %s exp %h got %h", nm, e, a); end end
module reset_and_brownout_control_tb;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic        wd_ov = 1'b0;
	logic        wd_en = 1'b0;
	logic        dbg = 1'b0;
	logic        stop_rel = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        we = 1'b0;
	logic        re = 1'b0;
	logic        rd_pend = 1'b0;
	logic [7:0]  opt = 8'h00;
	logic [7:0]  ev;
	logic [3:0]  lvl;
	logic [3:0]  ulvl;
	logic [7:0]  exp_q[$];
	logic        pin_n, supply_low, warn_trip, sys_reset, cpu_start, bo_dis_n, uv_en;
	logic [7:0]  rdata, cfg_q;
	logic [15:0] vec;
	logic [3:0]  bo_lvl, uv_lvl;
	int          seed = 24258;
	int          n_fail = 0;
	int          checks_done = 0;
	int          n;
	always #2 ref_clk = ~ref_clk;
	reset_and_brownout_control #(.CFG_DELAY_CYC(22'd20), .RELEASE_CYC(22'd40))
	u_reset_and_brownout_control (.ref_clk(ref_clk), .rst(rst), .ce(ce),
		.ext_reset_n_pin(pin_n), .watchdog_overflow(wd_ov), .watchdog_enable(wd_en),
		.brownout_detect(supply_low), .debug_reset_req(dbg), .lvi_detect(warn_trip),
		.stop_release(stop_rel), .cfg_option_bytes(opt), .reg_addr(addr),
		.reg_wdata(wdata), .reg_we(we), .reg_re(re), .reg_rdata(rdata),
		.sys_reset(sys_reset), .cpu_start(cpu_start), .start_vector(vec),
		.config_options(cfg_q), .brownout_disable_n(bo_dis_n),
		.brownout_level_sel(bo_lvl), .undervoltage_warn_enable(uv_en),
		.undervoltage_warn_level(uv_lvl));
	reset_far_side u_reset_far_side (.ref_clk(ref_clk), .pin_n(pin_n),
		.supply_low(supply_low), .warn_trip(warn_trip));
	// Read data are checked in the cycle after the strobe
	always @(posedge ref_clk) begin
		if (rd_pend) begin
			ev = exp_q.pop_front();
			`CHK("rdata", ev, rdata)
		end
		rd_pend <= re;
	end
	task automatic summarize();
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge ref_clk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		addr <= a;
		re <= 1'b1;
		exp_q.push_back(e);
		@(posedge ref_clk);
		re <= 1'b0;
	endtask
	// Bounded wait for the start pulse; n counts the clocks waited
	task automatic wait_start(output int n);
		for (n = 0; n < 4000; n++) begin
			@(posedge ref_clk);
			if (cpu_start === 1'b1) return;
		end
		n_fail++;
		summarize();
	endtask
	initial begin
		opt <= 8'($random(seed)) | 8'h01;
		lvl = 4'($unsigned($random(seed)) % 14);
		ulvl = 4'($unsigned($random(seed)) % 13);
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		wait_start(n);
		`CHK("por_len", 1'b1, (n >= 40 && n <= 50))
		`CHK("options", opt, cfg_q)
		`CHK("vector", 16'h0000, vec)
		rd(8'he8, 8'h80);
		rd(8'hd8, 8'h00);
		rd(8'h86, 8'h00);
		// Clock enable low: a write in the frozen cycles is lost
		ce <= 1'b0;
		wr(8'h86, 8'h1f);
		ce <= 1'b1;
		rd(8'h86, 8'h00);
		wr(8'h10, 8'hff);
		rd(8'h10, 8'h00);
		// Brown-out control: legal level, then both unavailable codes
		wr(8'hd8, {1'b1, 2'b00, lvl, 1'b1});
		for (int c = 14; c < 16; c++) wr(8'hd8, {1'b1, 2'b00, 4'(c), 1'b1});
		rd(8'hd8, {1'b1, 2'b00, lvl, 1'b1});
		`CHK("bo_lvl", lvl, bo_lvl)
		u_reset_far_side.dip(1'b0, 3);
		`CHK("bo_off", 1'b0, sys_reset)
		// Indicator control, flag set by the comparator
		wr(8'h86, {4'h1, ulvl});
		wr(8'h86, 8'h1d);
		u_reset_far_side.dip(1'b1, 3);
		rd(8'h86, {4'h3, ulvl});
		`CHK("uv_lvl", ulvl, uv_lvl)
		`CHK("uv_en", 1'b1, uv_en)
		// Stop release re-enables the brown-out reset
		stop_rel <= 1'b1;
		@(posedge ref_clk);
		stop_rel <= 1'b0;
		@(posedge ref_clk);
		`CHK("stop_on", 1'b0, bo_dis_n)
		// Short glitch ignored, long low resets
		u_reset_far_side.pull_low(100);
		repeat (10) @(posedge ref_clk);
		`CHK("glitch", 1'b0, sys_reset)
		u_reset_far_side.pull_low(2600);
		`CHK("pin_rst", 1'b1, sys_reset)
		wait_start(n);
		`CHK("pin_len", 1'b1, (n >= 40 && n <= 50))
		rd(8'he8, 8'hc0);
		rd(8'hd8, {3'b000, lvl, 1'b0});
		// Stop release leaves the bit alone when not selected
		wr(8'hd8, {3'b000, lvl, 1'b1});
		stop_rel <= 1'b1;
		@(posedge ref_clk);
		stop_rel <= 1'b0;
		rd(8'hd8, {3'b000, lvl, 1'b1});
		wr(8'hd8, {3'b000, lvl, 1'b0});
		wr(8'he8, 8'h00);
		rd(8'he8, 8'h00);
		// Watchdog gated by its enable, then debug, then brown-out
		wd_ov <= 1'b1;
		repeat (3) @(posedge ref_clk);
		`CHK("wd_off", 1'b0, sys_reset)
		wd_en <= 1'b1;
		@(posedge ref_clk);
		wd_ov <= 1'b0;
		wait_start(n);
		rd(8'he8, 8'h20);
		dbg <= 1'b1;
		@(posedge ref_clk);
		dbg <= 1'b0;
		wait_start(n);
		rd(8'he8, 8'h30);
		u_reset_far_side.dip(1'b0, 3);
		wait_start(n);
		rd(8'he8, 8'h38);
		wr(8'he8, 8'h08);
		rd(8'he8, 8'h08);
		// Second power-on reset in mid-run
		rst <= 1'b1;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		wait_start(n);
		rd(8'he8, 8'h80);
		rd(8'hd8, 8'h00);
		repeat (3) @(posedge ref_clk);
		summarize();
	end
endmodule
